// ---- strap_decode_status_lamps.sv ----
/*
  Strap decoder and status lamp driver. Captures jumper straps after reset,
  decodes board settings, steps the power-on self-test display and then drives
  run or monitor lamps. Registers over AXI4-Lite.
  Assumes straps are static, inputs are synchronous to clk, and an external
  test engine reports a failing diagnostic by pulsing diagFault.
*/
`timescale 1ns/1ps
`default_nettype none

module strap_decode_status_lamps
  import strap_lamp_pkg::*;
#(
  parameter int unsigned STEP_LEN    = STEP_CYCLES,
  parameter int unsigned FLICKER_LEN = FLICKER_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire strap_pins_t straps,
  input  wire logic        diagFault,
  input  wire logic        serialActive,
  input  wire logic        scsiBusBusy,
  output logic [3:0]       statusLamp,
  output logic             boardHealthGreen,
  output logic             boardHealthRed,
  output logic             busActivityLamp,
  output logic             sysfailAsserted,
  output logic             scsiBusReset,
  output logic             scsiBusInit,
  output logic             fwLoadDone,
  output settings_t        settings,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  logic        rstMeta_q;
  logic        rstn;
  logic        captured_q;
  mode_t       mode_q;
  logic [3:0]  diagCode_q;
  logic [31:0] stepCnt_q;
  logic [31:0] flickCnt_q;
  logic        flickTick;
  logic        testPassed_q;
  logic        busInitDone_q;
  logic        initRequest_q;
  logic [15:0] cmdCount_q;
  logic [3:0]  awAddr_q;
  logic        awHeld_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        wHeld_q;
  logic        doWrite;
  logic [3:0]  nextCode;

  // two-stage reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_q <= 1'b0;
      rstn      <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstn      <= rstMeta_q;
    end
  end

  // straps caught on the first edge after release, then frozen
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      captured_q <= 1'b0;
      settings   <= '0;
    end else if (!captured_q) begin
      captured_q                 <= 1'b1;
      settings.primaryId         <= straps.idAndGrant[7:5];
      settings.secondaryId       <= straps.idAndGrant[4:2];
      settings.grantLevel        <= straps.idAndGrant[1:0];
      settings.window2Size       <= ~straps.bootAndWindow2[1:0];
      settings.window1Size       <= ~straps.window1AndReset[3:2];
      settings.blockModeEn       <= straps.hostOption[3];
      settings.sysfailAfterTest  <= ~straps.hostOption[2];
      settings.powerupBusResetEn <= straps.hostOption[1];
      settings.fwFromBuffer      <= ~straps.bootAndWindow2[3];
      settings.haltInMonitor     <= ~straps.bootAndWindow2[2];
      settings.delayedBusInit    <= ~straps.startupOption[3];
      settings.memTestEn         <= straps.startupOption[2];
      settings.consoleEn         <= straps.startupOption[1];
      settings.secMcrResetEn     <= ~straps.window1AndReset[1];
      settings.priMcrResetEn     <= ~straps.window1AndReset[0];
    end
  end

  // memory tests (SRAM and buffer) are skipped when disabled by strap
  always_comb begin
    nextCode = diagCode_q + 4'h1;
    if (!settings.memTestEn && diagCode_q == DIAG_CORE_LAST) begin
      nextCode = DIAG_BUFFER_LAST + 4'h1;
    end
  end

  // self-test sequencer and mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q       <= ST_CAPTURE;
      diagCode_q   <= 4'h0;
      stepCnt_q    <= '0;
      testPassed_q <= 1'b0;
      fwLoadDone   <= 1'b0;
    end else begin
      unique case (mode_q)
        ST_CAPTURE: begin
          if (captured_q) begin
            mode_q     <= ST_POWER_ON_SELFTEST_MODE;
            diagCode_q <= DIAG_FIRST;
            stepCnt_q  <= '0;
          end
        end
        ST_POWER_ON_SELFTEST_MODE: begin
          if (diagFault) begin
            mode_q <= ST_FAULT;
          end else if (stepCnt_q == STEP_LEN - 1) begin
            stepCnt_q <= '0;
            if (diagCode_q == DIAG_LAST) begin
              mode_q       <= ST_LOAD;
              testPassed_q <= 1'b1;
            end else begin
              diagCode_q <= nextCode;
            end
          end else begin
            stepCnt_q <= stepCnt_q + 32'h1;
          end
        end
        ST_FAULT: begin
          mode_q <= ST_FAULT;
        end
        ST_LOAD: begin
          fwLoadDone <= 1'b1;
          mode_q     <= settings.haltInMonitor ? ST_MONITOR : ST_RUN;
        end
        ST_RUN: begin
          mode_q <= ST_RUN;
        end
        ST_MONITOR: begin
          mode_q <= ST_MONITOR;
        end
      endcase
    end
  end

  // flicker divider for monitor mode
  assign flickTick = (flickCnt_q == FLICKER_LEN - 1);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flickCnt_q <= '0;
    end else if (mode_q != ST_MONITOR || flickTick) begin
      flickCnt_q <= '0;
    end else begin
      flickCnt_q <= flickCnt_q + 32'h1;
    end
  end

  // status lamps
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      statusLamp <= 4'h0;
    end else begin
      unique case (mode_q)
        ST_CAPTURE: statusLamp <= 4'h0;
        ST_POWER_ON_SELFTEST_MODE, ST_FAULT: statusLamp <= diagCode_q;
        ST_LOAD: statusLamp <= 4'h0;
        ST_RUN: begin
          if (cmdCount_q == CMD_COUNT_RESET) begin
            statusLamp <= 4'h0;
          end else if (cmdCount_q <= BAR_ONE_MAX) begin
            statusLamp <= 4'h1;
          end else if (cmdCount_q <= BAR_TWO_MAX) begin
            statusLamp <= 4'h3;
          end else if (cmdCount_q <= BAR_THREE_MAX) begin
            statusLamp <= 4'h7;
          end else begin
            statusLamp <= 4'hF;
          end
        end
        ST_MONITOR: begin
          if (!serialActive) begin
            statusLamp <= 4'h0;
          end else if (statusLamp == 4'h0) begin
            statusLamp <= 4'h1;
          end else if (flickTick) begin
            statusLamp <= {statusLamp[2:0], statusLamp[3]};
          end
        end
      endcase
    end
  end

  // health, bus activity and sysfail
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boardHealthGreen <= 1'b0;
      boardHealthRed   <= 1'b1;
      busActivityLamp  <= 1'b0;
      sysfailAsserted  <= 1'b1;
    end else begin
      boardHealthGreen <= testPassed_q;
      boardHealthRed   <= !testPassed_q;
      busActivityLamp  <= scsiBusBusy;
      // sysfail held through capture so the strap choice is known first
      if (mode_q == ST_POWER_ON_SELFTEST_MODE && !settings.sysfailAfterTest) begin
        sysfailAsserted <= 1'b0;
      end else if (testPassed_q) begin
        sysfailAsserted <= 1'b0;
      end
    end
  end

  // power-up bus reset and bus initialisation pulses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scsiBusReset  <= 1'b0;
      scsiBusInit   <= 1'b0;
      busInitDone_q <= 1'b0;
    end else begin
      scsiBusReset <= (mode_q == ST_LOAD) && settings.powerupBusResetEn;
      scsiBusInit  <= 1'b0;
      if (testPassed_q && !busInitDone_q
          && (!settings.delayedBusInit || initRequest_q)) begin
        scsiBusInit   <= 1'b1;
        busInitDone_q <= 1'b1;
      end
    end
  end

  // axi4-lite write path: address and data taken in either order
  assign doWrite = awHeld_q && wHeld_q && !bvalid;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awready  <= 1'b0;
      awHeld_q <= 1'b0;
      awAddr_q <= 4'h0;
    end else if (awready && awvalid) begin
      awready  <= 1'b0;
      awHeld_q <= 1'b1;
      awAddr_q <= awaddr;
    end else if (doWrite) begin
      awHeld_q <= 1'b0;
    end else if (!awHeld_q && !bvalid && !awready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wready  <= 1'b0;
      wHeld_q <= 1'b0;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
    end else if (wready && wvalid) begin
      wready  <= 1'b0;
      wHeld_q <= 1'b1;
      wData_q <= wdata;
      wStrb_q <= wstrb;
    end else if (doWrite) begin
      wHeld_q <= 1'b0;
    end else if (!wHeld_q && !bvalid && !wready) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp  <= (awAddr_q[3:2] == REG_CMD_COUNT[3:2] || awAddr_q[3:2] == REG_HOST_CMD[3:2])
                ? RESP_OKAY : RESP_DECERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // writable registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmdCount_q    <= CMD_COUNT_RESET;
      initRequest_q <= 1'b0;
    end else if (doWrite) begin
      if (awAddr_q[3:2] == REG_CMD_COUNT[3:2]) begin
        if (wStrb_q[0]) begin
          cmdCount_q[7:0] <= wData_q[7:0];
        end
        if (wStrb_q[1]) begin
          cmdCount_q[15:8] <= wData_q[15:8];
        end
      end
      if (awAddr_q[3:2] == REG_HOST_CMD[3:2] && wStrb_q[0]
          && wData_q[7:0] == CMD_INIT_BUS) begin
        initRequest_q <= 1'b1;
      end
    end
  end

  // axi4-lite read path: one read at a time, data one cycle after address
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end else if (arready && arvalid) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= RESP_OKAY;
      unique case (araddr[3:2])
        REG_CMD_COUNT[3:2]: rdata <= {16'h0, cmdCount_q};
        REG_HOST_CMD[3:2]:  rdata <= {31'h0, initRequest_q};
        REG_STATUS[3:2]:    rdata <= {16'h0, busInitDone_q, testPassed_q,
                                      sysfailAsserted, fwLoadDone, 1'b0, mode_q,
                                      statusLamp, diagCode_q};
        REG_SETTINGS[3:2]:  rdata <= {10'h000, settings};
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid && !arready) begin
      arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- strap_lamp_pkg.sv ----
/*
  Shared constants and types for the strap decoder and status lamp driver:
  register offsets, diagnostic codes, timing figures, strap and settings layouts.
  Assumes a 100 MHz board clock.
*/
package strap_lamp_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned SELFTEST_MS      = 200;
  localparam int unsigned FLICKER_MS       = 50;
  localparam int unsigned SELFTEST_CYCLES  = SELFTEST_MS * 1000 * CLK_MHZ;
  localparam int unsigned FLICKER_CYCLES   = FLICKER_MS * 1000 * CLK_MHZ;

  // diagnostic numbers
  localparam logic [3:0] DIAG_FIRST        = 4'h1;
  localparam logic [3:0] DIAG_CORE_LAST    = 4'h2;
  localparam logic [3:0] DIAG_RESERVED     = 4'h8;
  localparam logic [3:0] DIAG_BUFFER_LAST  = 4'hB;
  localparam logic [3:0] DIAG_LAST         = 4'hE;
  localparam int unsigned DIAG_COUNT       = 14;
  localparam int unsigned STEP_CYCLES      = SELFTEST_CYCLES / DIAG_COUNT;

  // bar graph thresholds of outstanding commands
  localparam logic [15:0] BAR_ONE_MAX      = 16'h0004;
  localparam logic [15:0] BAR_TWO_MAX      = 16'h0010;
  localparam logic [15:0] BAR_THREE_MAX    = 16'h0040;

  // host command that starts a delayed bus initialisation
  localparam logic [7:0] CMD_INIT_BUS      = 8'h41;

  // register map (byte addresses)
  localparam logic [3:0] REG_CMD_COUNT     = 4'h0;
  localparam logic [3:0] REG_HOST_CMD      = 4'h4;
  localparam logic [3:0] REG_STATUS        = 4'h8;
  localparam logic [3:0] REG_SETTINGS      = 4'hC;
  localparam logic [15:0] CMD_COUNT_RESET  = 16'h0000;

  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_DECERR       = 2'h3;

  // strap pins: 1 = open, 0 = fitted
  typedef struct packed {
    logic [7:0] idAndGrant;     // pins 1-2 .. 15-16, bit 7 = pins 1-2
    logic [3:0] hostOption;     // bit 3 = pins 1-2
    logic [3:0] bootAndWindow2;
    logic [3:0] startupOption;
    logic [3:0] window1AndReset;
  } strap_pins_t;

  typedef struct packed {
    logic [2:0] primaryId;
    logic [2:0] secondaryId;
    logic [1:0] grantLevel;
    logic [1:0] window2Size;    // 0=256 1=512 2=1K 3=2K
    logic [1:0] window1Size;
    logic       blockModeEn;
    logic       sysfailAfterTest;
    logic       powerupBusResetEn;
    logic       fwFromBuffer;
    logic       haltInMonitor;
    logic       delayedBusInit;
    logic       memTestEn;
    logic       consoleEn;
    logic       secMcrResetEn;
    logic       priMcrResetEn;
  } settings_t;

  typedef enum logic [2:0] {
    ST_CAPTURE, ST_POWER_ON_SELFTEST_MODE, ST_FAULT, ST_LOAD, ST_RUN, ST_MONITOR
  } mode_t;

endpackage

// ---- strap_lamp_assertions.sv ----
/*
  Concurrent checks on the strap decoder and lamp driver ports.
  Assumes one clock domain; bound to the top module at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none

module strap_lamp_assertions
  import strap_lamp_pkg::*;
(
  input wire logic      clk,
  input wire logic      resetn,
  input wire settings_t settings,
  input wire logic      scsiBusBusy,
  input wire logic      busActivityLamp,
  input wire logic      boardHealthGreen,
  input wire logic      boardHealthRed,
  input wire logic      scsiBusReset,
  input wire logic      scsiBusInit,
  input wire logic      fwLoadDone,
  input wire logic      awready,
  input wire logic      wready,
  input wire logic      bvalid,
  input wire logic      bready,
  input wire logic      arready,
  input wire logic      rvalid
);
  logic [2:0] upCnt;

  // the reset synchroniser and strap capture take a few edges to settle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) upCnt <= 3'h0;
    else if (upCnt != 3'h7) upCnt <= upCnt + 3'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  bus_lamp_a: assert property (upCnt > 3'h4 |-> busActivityLamp == $past(scsiBusBusy))
    else $error("bus lamp does not follow bus busy");
  health_excl_a: assert property (boardHealthGreen |-> !boardHealthRed)
    else $error("health lamp shows both colours");
  settings_hold_a: assert property (upCnt > 3'h4 |-> $stable(settings))
    else $error("settings changed after capture");
  reset_pulse_a: assert property (scsiBusReset |-> fwLoadDone ##1 !scsiBusReset)
    else $error("bus reset pulse malformed");
  init_pulse_a: assert property (scsiBusInit |=> !scsiBusInit)
    else $error("bus init pulse longer than one cycle");
  b_done_a: assert property (bvalid && bready |=> !bvalid)
    else $error("write response not retired");
  b_busy_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  r_busy_a: assert property (rvalid |-> !arready)
    else $error("read accepted while data pending");
endmodule

bind strap_decode_status_lamps strap_lamp_assertions chk_u (
  .clk, .resetn, .settings, .scsiBusBusy, .busActivityLamp, .boardHealthGreen,
  .boardHealthRed, .scsiBusReset, .scsiBusInit, .fwLoadDone, .awready, .wready,
  .bvalid, .bready, .arready, .rvalid
);

`default_nettype wire

// ---- strap_panel_model.sv ----
/*
  Behavioural jumper panel and bus-busy source beside the block.
  Assumes the bench sets the fitted straps; open pins float high on pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none

module strap_panel_model
  import strap_lamp_pkg::*;
(
  input  wire strap_pins_t fitted,
  input  wire logic        busyReq,
  output var strap_pins_t  straps,
  output logic             scsiBusBusy
);
  // a fitted strap shorts its pin low; an open one is pulled up
  assign straps = ~fitted;
  assign scsiBusBusy = busyReq;
endmodule

`default_nettype wire

// ---- testbench.sv ----
/*
  Self-checking bench for the strap decoder and lamp driver.
  Assumes shortened self-test steps (4 cycles) and a 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench
  import strap_lamp_pkg::*;
;
  localparam strap_pins_t DEF = 24'h00030D;
  logic        clk = 1'b0, resetn = 1'b0, diagFault = 1'b0, serialActive = 1'b0;
  logic        busyReq = 1'b0, scsiBusBusy;
  strap_pins_t fitMask = '0, straps;
  logic [3:0]  statusLamp, awaddr, araddr, wstrb;
  logic        boardHealthGreen, boardHealthRed, busActivityLamp, sysfailAsserted;
  logic        scsiBusReset, scsiBusInit, fwLoadDone;
  settings_t   settings;
  logic [31:0] wdata, rdata;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  int          n_mismatch = 0, n_compared = 0, nRst = 0, nInit = 0;
  time         tRel;

  strap_panel_model panel_u (.fitted(fitMask), .busyReq, .straps, .scsiBusBusy);
  strap_decode_status_lamps #(.STEP_LEN(4), .FLICKER_LEN(3)) dut_u (
    .clk, .resetn, .straps, .diagFault, .serialActive, .scsiBusBusy, .statusLamp,
    .boardHealthGreen, .boardHealthRed, .busActivityLamp, .sysfailAsserted,
    .scsiBusReset, .scsiBusInit, .fwLoadDone, .settings, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);

  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (scsiBusReset === 1'b1) nRst++;
    if (scsiBusInit === 1'b1) nInit++;
  end

  function automatic settings_t dec(input strap_pins_t p);
    return {p.idAndGrant, ~p.bootAndWindow2[1:0], ~p.window1AndReset[3:2], p.hostOption[3],
            ~p.hostOption[2], p.hostOption[1], ~p.bootAndWindow2[3:2], ~p.startupOption[3],
            p.startupOption[2:1], ~p.window1AndReset[1:0]};
  endfunction

  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic hang(input string what);
    n_mismatch++;
    $display("CHECK FAILED %s expected event seen timeout", what);
    final_report;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic do_reset(input strap_pins_t f);
    @(posedge clk);
    resetn <= 1'b0;
    fitMask <= f;
    tick(10);
    resetn <= 1'b1;
    tRel = $time;
    nRst = 0;
    nInit = 0;
  endtask

  task automatic wait_lamp(input logic [3:0] v);
    for (int i = 0; i < 40 && statusLamp !== v; i++) @(posedge clk);
    if (statusLamp !== v) hang("statusLamp");
  endtask

  // returns self-test length in cycles from reset release
  task automatic wait_green(output int len);
    for (int i = 0; i < 200 && boardHealthGreen !== 1'b1; i++) @(posedge clk);
    if (boardHealthGreen !== 1'b1) hang("boardHealthGreen");
    len = int'(($time - tRel) / 10);
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (bvalid !== 1'b1) hang("bvalid");
    chk("bresp", bresp, r);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] e, input string what);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (rvalid !== 1'b1) hang("rvalid");
    chk(what, rdata, e);
    chk("rresp", rresp, RESP_OKAY);
    rready <= 1'b0;
  endtask

  task automatic s_defaults;
    logic [15:0] cnt [8] = '{16'h0000, 16'h0001, 16'h0004, 16'h0005,
                             16'h0010, 16'h0011, 16'h0040, 16'h0041};
    logic [3:0]  bar [8] = '{4'h0, 4'h1, 4'h1, 4'h3, 4'h3, 4'h7, 4'h7, 4'hF};
    int          len;
    do_reset(DEF);
    wait_lamp(4'h1);
    tick(2);
    chk("sysfailEarly", sysfailAsserted, 1'b0);
    for (int c = 2; c <= 14; c++) wait_lamp(4'(c));
    wait_green(len);
    chk("postLength", len inside {[56:66]}, 1'b1);
    chk("healthRed", boardHealthRed, 1'b0);
    tick(3);
    chk("busResets", nRst, 1);
    chk("busInits", nInit, 1);
    chk("fwLoadDone", fwLoadDone, 1'b1);
    chk("settings", settings, dec(~DEF));
    chk("defaultIds", {settings.primaryId, settings.secondaryId, settings.grantLevel}, 8'hFF);
    chk("defaultWindows", {settings.window2Size, settings.window1Size}, 4'hF);
    axi_rd(REG_SETTINGS, {10'h000, dec(~DEF)}, "settingsReg");
    for (int i = 0; i < 8; i++) begin
      axi_wr(REG_CMD_COUNT, {16'h0000, cnt[i]}, RESP_OKAY);
      tick(3);
      chk("barLamps", statusLamp, bar[i]);
    end
    axi_rd(REG_CMD_COUNT, 32'h00000041, "cmdCount");
    axi_wr(REG_STATUS, 32'h0000FFFF, RESP_DECERR);
    busyReq <= 1'b1;
    tick(3);
    chk("busLampOn", busActivityLamp, 1'b1);
    busyReq <= 1'b0;
    tick(3);
    chk("busLampOff", busActivityLamp, 1'b0);
  endtask

  task automatic s_options;
    strap_pins_t f;
    int          len;
    f = 24'hA5EDEA;
    do_reset(f);
    tick(5);
    chk("settings", settings, dec(~f));
    chk("ids", {settings.primaryId, settings.secondaryId, settings.grantLevel}, 8'h5A);
    chk("windows", {settings.window2Size, settings.window1Size}, 4'h6);
    wait_lamp(4'hC);
    chk("sysfailHeld", sysfailAsserted, 1'b1);
    wait_green(len);
    chk("shortPost", len inside {[20:30]}, 1'b1);
    tick(3);
    chk("sysfailLate", sysfailAsserted, 1'b0);
    chk("noBusReset", nRst, 0);
    chk("noEarlyInit", nInit, 0);
    axi_wr(REG_CMD_COUNT, 32'h00000041, RESP_OKAY);
    tick(3);
    chk("monitorIdle", statusLamp, 4'h0);
    serialActive <= 1'b1;
    for (int i = 0; i < 5; i++) wait_lamp(4'h1 << (i % 4));
    serialActive <= 1'b0;
    axi_wr(REG_HOST_CMD, 32'h00000040, RESP_OKAY);
    tick(3);
    chk("wrongCmdInit", nInit, 0);
    axi_wr(REG_HOST_CMD, {24'h000000, CMD_INIT_BUS}, RESP_OKAY);
    tick(3);
    chk("cmdInit", nInit, 1);
    axi_rd(REG_HOST_CMD, 32'h00000001, "hostCmdReg");
    fitMask <= '0;
    tick(3);
    chk("heldSettings", settings, dec(~f));
  endtask

  task automatic s_fault;
    do_reset(DEF);
    wait_lamp(4'h3);
    diagFault <= 1'b1;
    tick(2);
    diagFault <= 1'b0;
    tick(20);
    chk("faultLamps", statusLamp, 4'h3);
    chk("faultHealth", {boardHealthRed, boardHealthGreen}, 2'h2);
    axi_rd(REG_STATUS, 32'h00000233, "faultStatus");
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
    s_defaults;
    s_options;
    s_fault;
    final_report;
  end
endmodule

`default_nettype wire
